// *** hw/fhtc_ctrl.v ***
/*
 * host transfer control of a floppy controller core: resets, modes,
 * command/execution/result phases, fifo flow control and dma.
 * assumes a disk engine on the core ports and a host on a plain port.
 */
`include "fhtc_defs.vh"
module fhtc_ctrl #(
   parameter FIFO_AW = 4
) (
   input  wire        ref_clk,
   input  wire        reset,
   input  wire [2:0]  addr,
   input  wire [7:0]  wdata,
   input  wire        wr,
   input  wire        rd,
   output wire [7:0]  rdata,
   input  wire        dma_ack_n,
   input  wire        terminal_count,
   output wire        fdc_irq_out,
   output wire        fdc_irq_oe,
   output wire        dma_request_out,
   output wire        dma_request_oe,
   output wire        density_select,
   output wire        core_reset,
   output wire        core_exec,
   output wire        core_write,
   output wire        core_tc,
   input  wire        core_rd_valid,
   input  wire [7:0]  core_rd_data,
   input  wire        core_sector_last,
   output wire        core_rd_ready,
   input  wire        core_wr_take,
   output wire        core_wr_avail,
   output wire [7:0]  core_wr_data,
   input  wire        core_done,
   input  wire        core_overrun
);
   // ************************************************************
   // phase states
   // ************************************************************
   localparam PH_CMD  = 4'b0001;  // taking command bytes
   localparam PH_PROC = 4'b0010;  // processing a written byte
   localparam PH_EXEC = 4'b0100;  // data transfer
   localparam PH_RES  = 4'b1000;  // result bytes out

   reg  [3:0]  phase;       // current phase
   reg  [3:0]  byte_idx;    // command bytes taken
   reg  [2:0]  res_idx;     // result bytes read
   reg  [2:0]  res_cnt;     // result bytes to read
   reg  [4:0]  cmd_op;      // opcode of command
   reg  [7:0]  prm [0:8];   // command and parameter bytes
   reg  [7:0]  res_st0;     // first result byte
   reg  [7:0]  res_st1;     // second result byte
   reg         irq_flag;    // phase interrupt
   reg         inv_pend;    // invalid command waiting for sense
   reg         fifo_on;     // fifo enabled by configure
   reg  [3:0]  fifo_level_param; // programmed threshold
   reg         exec_wr;     // host to disk transfer
   reg         tc_seen;     // terminal count taken
   reg         done_seen;   // engine finished sector
   reg         ovr_seen;    // overrun or underrun
   reg         xfer_req;    // service request
   reg         last_in;     // sector's last byte in fifo
   reg         ack_q;       // ack one cycle ago
   reg  [7:0]  option_config_reg; // mode and dma style
   reg  [7:0]  drive_output_reg;  // reset and dma enable
   reg         dsr_rst;     // self clearing reset
   reg  [1:0]  rate_sel;    // data rate select
   reg         spec_nd;     // non-dma selected by specify
   reg  [7:0]  spec_t0;     // specify timing byte one
   reg  [7:0]  spec_t1;     // specify timing byte two
   reg  [7:0]  reg_rdata;   // registered read data
   reg         rd_fifo_q;   // last read took fifo
   reg  [3:0]  op_total;    // bytes in command
   reg         op_valid;    // opcode known
   reg         next_req;    // next service request
   reg  [7:0]  res_byte;    // current result byte

   wire        core_rst;    // pin or soft reset
   wire [FIFO_AW:0] f_count;   // fifo fill
   wire [7:0]  f_dout;      // fifo head
   wire        f_push;      // fifo push
   wire        f_pop;       // fifo pop
   wire        f_empty;     // fifo empty
   wire        f_full;      // fifo full at effective depth
   wire [4:0]  depth_eff;   // 16 or one byte
   wire [4:0]  thr;         // effective threshold
   wire [4:0]  lvl_rd;      // read request level
   wire [4:0]  lvl_wr;      // write request level
   wire        in_exec;     // execution phase
   wire        dma_mode;    // dma transfers
   wire        ack;         // qualified dma ack
   wire        host_wr;     // host write to fifo
   wire        host_rd;     // host read from fifo
   wire        pseudo_rd;   // verify cycle pop
   wire        cmd_wr;      // command byte write
   wire        res_rd;      // result byte read
   wire        tc_act;      // tc after polarity
   wire        out_en;      // irq and dma drive enable
   wire        single;      // single transfer style
   wire        request_for_master;         // request for master
   wire        transfer_direction;         // transfer direction
   wire        cb;          // command busy
   wire [7:0]  msr;         // main status
   wire        dens_hi;     // high density rate

   // ************************************************************
   // resets
   // ************************************************************
   // both soft resets act alike; drive reset is held by software
   assign core_rst   = reset | drive_output_reg[`FHTC_DOR_RST] | dsr_rst;
   assign core_reset = core_rst;

   // ************************************************************
   // mode and pin polarity
   // ************************************************************
   assign dens_hi = (rate_sel == 2'b00) | (rate_sel == 2'b11);
   fhtc_mode u_mode (
      .ident       (option_config_reg[`FHTC_OPT_IDENT]),
      .variant     (option_config_reg[`FHTC_OPT_VARIANT]),
      .dma_en_bit  (drive_output_reg[`FHTC_DOR_DMAEN]),
      .tc_pin      (terminal_count),
      .dens_hi     (dens_hi),
      .out_enable  (out_en),
      .tc_active   (tc_act),
      .density_pin (density_select)
   );
   assign single = option_config_reg[`FHTC_OPT_SINGLE];

   // ************************************************************
   // access decode
   // ************************************************************
   assign in_exec  = phase == PH_EXEC;
   assign dma_mode = ~spec_nd;
   // ack alone selects the fifo, no address needed
   assign ack      = ~dma_ack_n & dma_mode & in_exec;
   assign host_wr  = wr & in_exec & exec_wr & ~f_full &
                     (ack | (addr == `FHTC_A_DATA));
   assign host_rd  = rd & in_exec & ~exec_wr & ~f_empty &
                     (ack | (addr == `FHTC_A_DATA));
   // byte mode read pops on each new ack without a strobe
   assign pseudo_rd = ack & ~ack_q & ~fifo_on & ~exec_wr & ~rd & ~f_empty;
   assign cmd_wr   = wr & ~ack & (addr == `FHTC_A_DATA) & (phase == PH_CMD);
   assign res_rd   = rd & ~ack & (addr == `FHTC_A_DATA) & (phase == PH_RES);

   // ************************************************************
   // fifo and flow levels
   // ************************************************************
   assign depth_eff = fifo_on ? `FHTC_FIFO_BYTES : `FHTC_BYTE_DEPTH;
   assign thr      = {1'b0, fifo_level_param} + 5'd1;
   assign lvl_rd   = fifo_on ? (`FHTC_FIFO_BYTES - thr) : `FHTC_BYTE_DEPTH;
   assign lvl_wr   = fifo_on ? thr : 5'd0;
   assign f_empty  = f_count == {(FIFO_AW+1){1'b0}};
   assign f_full   = f_count >= depth_eff;
   assign f_push   = host_wr | (core_rd_valid & core_rd_ready);
   assign f_pop    = host_rd | pseudo_rd | (core_wr_take & core_wr_avail);
   assign core_rd_ready = in_exec & ~exec_wr & ~f_full;
   assign core_wr_avail = in_exec & exec_wr & ~f_empty;
   assign core_wr_data  = f_dout;
   assign core_exec     = in_exec;
   assign core_write    = exec_wr;
   assign core_tc       = tc_seen;

   fhtc_fifo #(
      .W  (8),
      .AW (FIFO_AW)
   ) u_fifo (
      .clk   (ref_clk),
      .rst   (core_rst),
      .push  (f_push),
      .din   (exec_wr ? wdata : core_rd_data),
      .pop   (f_pop),
      .dout  (f_dout),
      .count (f_count)
   );

   // ************************************************************
   // command decode
   // ************************************************************
   always @* begin
      op_total = 4'd0;
      op_valid = 1'b1;
      case (cmd_op)
         `FHTC_OP_SPECIFY: op_total = `FHTC_TB_SPECIFY;
         `FHTC_OP_CONFIG:  op_total = `FHTC_TB_CONFIG;
         `FHTC_OP_READ:    op_total = `FHTC_TB_RW;
         `FHTC_OP_WRITE:   op_total = `FHTC_TB_RW;
         `FHTC_OP_SENSE:   op_total = `FHTC_TB_SENSE;
         default:          op_valid = 1'b0;
      endcase
   end

   // next service request for the fifo
   always @* begin
      next_req = xfer_req;
      if (!exec_wr) begin
         if (f_empty)
            next_req = 1'b0;
         else if ((f_count >= lvl_rd) || last_in)
            next_req = 1'b1;
      end else begin
         if (tc_seen || f_full)
            next_req = 1'b0;
         else if (f_count <= lvl_wr)
            next_req = 1'b1;
      end
   end

   // ************************************************************
   // phase sequencer
   // ************************************************************
   always @(posedge ref_clk) begin
      if (core_rst) begin
         phase            <= PH_CMD;
         byte_idx         <= 4'd0;
         res_idx          <= 3'd0;
         res_cnt          <= 3'd0;
         cmd_op           <= 5'd0;
         res_st0          <= 8'h00;
         res_st1          <= 8'h00;
         irq_flag         <= 1'b0;
         inv_pend         <= 1'b0;
         fifo_on          <= 1'b0;
         fifo_level_param <= 4'd0;
         exec_wr          <= 1'b0;
         tc_seen          <= 1'b0;
         done_seen        <= 1'b0;
         ovr_seen         <= 1'b0;
         xfer_req         <= 1'b0;
         last_in          <= 1'b0;
      end else begin
         case (phase)
            // one byte in, ready drops while it is processed
            PH_CMD: begin
               if (cmd_wr) begin
                  if (byte_idx == 4'd0)
                     cmd_op <= wdata[4:0];
                  byte_idx <= byte_idx + 4'd1;
                  irq_flag <= 1'b0;
                  phase    <= PH_PROC;
               end
            end
            PH_PROC: begin
               if (!op_valid) begin
                  irq_flag <= 1'b1;
                  inv_pend <= 1'b1;
                  byte_idx <= 4'd0;
                  phase    <= PH_CMD;
               end else if (byte_idx != op_total) begin
                  phase <= PH_CMD;
               end else begin
                  byte_idx <= 4'd0;
                  res_idx  <= 3'd0;
                  case (cmd_op)
                     `FHTC_OP_CONFIG: begin
                        fifo_on          <= ~prm[2][`FHTC_CFG_FIFOOFF];
                        fifo_level_param <= prm[2][3:0];
                        phase            <= PH_CMD;
                     end
                     `FHTC_OP_SENSE: begin
                        // result phase opens with the interrupt
                        irq_flag <= 1'b1;
                        res_st0  <= inv_pend ? `FHTC_ST0_INVALID : 8'h00;
                        res_st1  <= 8'h00;
                        inv_pend <= 1'b0;
                        res_cnt  <= `FHTC_RB_SENSE;
                        phase    <= PH_RES;
                     end
                     `FHTC_OP_READ,
                     `FHTC_OP_WRITE: begin
                        exec_wr   <= cmd_op == `FHTC_OP_WRITE;
                        // write requests on entry to execution
                        xfer_req  <= cmd_op == `FHTC_OP_WRITE;
                        tc_seen   <= 1'b0;
                        done_seen <= 1'b0;
                        ovr_seen  <= 1'b0;
                        last_in   <= 1'b0;
                        phase     <= PH_EXEC;
                     end
                     default: phase <= PH_CMD;
                  endcase
               end
            end
            PH_EXEC: begin
               // tc counts when qualified by ack in dma mode
               if (tc_act && (ack || !dma_mode))
                  tc_seen <= 1'b1;
               if (core_overrun)
                  ovr_seen <= 1'b1;
               if (core_done)
                  done_seen <= 1'b1;
               if (core_rd_valid && core_rd_ready && core_sector_last)
                  last_in <= 1'b1;
               else if (f_empty)
                  last_in <= 1'b0;
               xfer_req <= next_req;
               // result once the engine is done and fifo drained
               if (done_seen && f_empty) begin
                  xfer_req <= 1'b0;
                  irq_flag <= 1'b1;
                  res_cnt  <= `FHTC_RB_RW;
                  res_st0  <= (tc_seen && !ovr_seen) ? 8'h00 : `FHTC_ST0_ABNORM;
                  res_st1  <= {~tc_seen, 2'b00, ovr_seen, 4'h0};
                  phase    <= PH_RES;
               end
            end
            PH_RES: begin
               if (res_rd) begin
                  irq_flag <= 1'b0;
                  res_idx  <= res_idx + 3'd1;
                  if (res_idx == res_cnt - 3'd1) begin
                     res_idx <= 3'd0;
                     phase   <= PH_CMD;
                  end
               end
            end
            default: phase <= PH_CMD;
         endcase
      end
   end

   // command and parameter byte store
   always @(posedge ref_clk) begin
      if (cmd_wr)
         prm[byte_idx] <= wdata;
   end

   // specify timing survives every reset
   always @(posedge ref_clk) begin
      if ((phase == PH_PROC) && op_valid && (byte_idx == op_total) &&
          (cmd_op == `FHTC_OP_SPECIFY) && !core_rst) begin
         spec_t0 <= prm[1];
         spec_t1 <= prm[2];
      end
   end

   // ************************************************************
   // host registers
   // ************************************************************
   always @(posedge ref_clk) begin
      if (reset) begin
         option_config_reg <= `FHTC_OPT_RST;
         drive_output_reg  <= `FHTC_DOR_RSTVAL;
         dsr_rst           <= 1'b0;
         rate_sel          <= 2'b00;
         spec_nd           <= 1'b0;
         ack_q             <= 1'b0;
      end else begin
         ack_q   <= ack;
         dsr_rst <= 1'b0;
         if (wr && !ack) begin
            case (addr)
               `FHTC_A_OPTCFG: option_config_reg <= wdata;
               `FHTC_A_DOR:    drive_output_reg  <= wdata;
               `FHTC_A_MSR: begin
                  dsr_rst  <= wdata[`FHTC_DSR_RST];
                  rate_sel <= wdata[1:0];
               end
               default: ;
            endcase
         end
         if ((phase == PH_PROC) && op_valid && (byte_idx == op_total) &&
             (cmd_op == `FHTC_OP_SPECIFY))
            spec_nd <= prm[2][`FHTC_SPEC_ND];
      end
   end

   // ************************************************************
   // status and read data
   // ************************************************************
   assign request_for_master = (phase == PH_CMD) | (phase == PH_RES) |
                (in_exec & spec_nd & xfer_req);
   assign transfer_direction = (phase == PH_RES) | (in_exec & ~exec_wr);
   assign cb  = (phase != PH_CMD) | (byte_idx != 4'd0);
   assign msr = {request_for_master, transfer_direction, in_exec & spec_nd, cb, 4'h0};

   // result byte by index
   always @* begin
      case (res_idx)
         3'd0:    res_byte = res_st0;
         3'd1:    res_byte = res_st1;
         3'd2:    res_byte = 8'h00;
         default: res_byte = prm[res_idx - 3'd1];
      endcase
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         rd_fifo_q <= 1'b0;
      end else begin
         rd_fifo_q <= host_rd;
         reg_rdata <= 8'h00;
         if (rd && !ack) begin
            case (addr)
               `FHTC_A_OPTCFG: reg_rdata <= option_config_reg;
               `FHTC_A_DOR:    reg_rdata <= drive_output_reg;
               `FHTC_A_MSR:    reg_rdata <= msr;
               `FHTC_A_DATA:   reg_rdata <= res_rd ? res_byte : 8'h00;
               `FHTC_A_SPEC:   reg_rdata <= spec_t0 ^ spec_t1;
               default:        reg_rdata <= 8'h00;
            endcase
         end
      end
   end
   assign rdata = rd_fifo_q ? f_dout : reg_rdata;

   // ************************************************************
   // interrupt and dma request pins
   // ************************************************************
   // non-dma write irq falls once tc ends the transfer
   assign fdc_irq_out = irq_flag |
                        (in_exec & spec_nd & xfer_req & ~(exec_wr & tc_seen));
   assign fdc_irq_oe  = out_en;
   // single style drops while ack stands, burst holds
   assign dma_request_out = in_exec & dma_mode & xfer_req & ~(single & ack);
   assign dma_request_oe  = out_en;
endmodule

// *** hw/fhtc_defs.vh ***
/*
 * constants shared by the floppy host transfer control block: register
 * offsets, bit positions, reset values, opcodes and byte counts.
 * assumes it is included by bare name from the transfer control design file.
 */
`ifndef FHTC_DEFS_VH
`define FHTC_DEFS_VH
// ************************************************************
// register offsets
// ************************************************************
`define FHTC_A_OPTCFG    3'h0
`define FHTC_A_DOR       3'h2
`define FHTC_A_MSR       3'h4
`define FHTC_A_DATA      3'h5
`define FHTC_A_SPEC      3'h6
// ************************************************************
// bit positions and reset values
// ************************************************************
`define FHTC_OPT_IDENT   3
`define FHTC_OPT_VARIANT 2
`define FHTC_OPT_SINGLE  1
`define FHTC_OPT_RST     8'h02
`define FHTC_DOR_RST     2
`define FHTC_DOR_DMAEN   3
`define FHTC_DOR_RSTVAL  8'h04
`define FHTC_DSR_RST     7
`define FHTC_MSR_RQM     7
`define FHTC_MSR_DIO     6
`define FHTC_MSR_NDMA    5
`define FHTC_MSR_CB      4
`define FHTC_CFG_FIFOOFF 5
`define FHTC_SPEC_ND     0
// ************************************************************
// opcodes, byte counts, status codes
// ************************************************************
`define FHTC_OP_SPECIFY  5'h03
`define FHTC_OP_WRITE    5'h05
`define FHTC_OP_READ     5'h06
`define FHTC_OP_SENSE    5'h08
`define FHTC_OP_CONFIG   5'h13
`define FHTC_TB_SPECIFY  4'd3
`define FHTC_TB_CONFIG   4'd4
`define FHTC_TB_RW       4'd9
`define FHTC_TB_SENSE    4'd1
`define FHTC_RB_RW       3'd7
`define FHTC_RB_SENSE    3'd2
`define FHTC_ST0_INVALID 8'h80
`define FHTC_ST0_ABNORM  8'h40
`define FHTC_FIFO_BYTES  5'd16
`define FHTC_BYTE_DEPTH  5'd1
`endif

// *** hw/fhtc_fifo.v ***
/*
 * data fifo memory with registered read data and a fill count.
 * assumes the caller never pushes when full nor pops when empty.
 */
module fhtc_fifo #(
   parameter W  = 8,
   parameter AW = 4
) (
   input  wire          clk,
   input  wire          rst,
   input  wire          push,
   input  wire [W-1:0]  din,
   input  wire          pop,
   output reg  [W-1:0]  dout,
   output reg  [AW:0]   count
);
   reg [W-1:0]  mem [0:(1<<AW)-1];  // storage
   reg [AW-1:0] wptr;               // write pointer
   reg [AW-1:0] rptr;               // read pointer
   // ************************************************************
   // pointers and count
   // ************************************************************
   always @(posedge clk) begin
      if (rst) begin
         wptr  <= {AW{1'b0}};
         rptr  <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wptr <= wptr + 1'b1;
         if (pop)
            rptr <= rptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
   // storage and registered head
   always @(posedge clk) begin
      if (push)
         mem[wptr] <= din;
      if (pop)
         dout <= mem[rptr];
   end
endmodule

// *** hw/fhtc_mode.v ***
/*
 * mode decode: output gating and pin polarities per mode.
 * assumes option and drive register bits arrive as levels.
 */
module fhtc_mode (
   input  wire ident,
   input  wire variant,
   input  wire dma_en_bit,
   input  wire tc_pin,
   input  wire dens_hi,
   output wire out_enable,
   output wire tc_active,
   output wire density_pin
);
   wire mode_a;  // identity high
   wire mode_b;  // identity low, variant high
   assign mode_a = ident;
   assign mode_b = ~ident & variant;
   // mode b drives always, a and c follow the dma enable bit
   assign out_enable  = mode_b | dma_en_bit;
   // tc is active low only in mode b
   assign tc_active   = mode_b ? ~tc_pin : tc_pin;
   // density is active high only in mode a
   assign density_pin = mode_a ? dens_hi : ~dens_hi;
endmodule

// *** test/fhtc_ctrl_monitor.sv ***
/* port checker for fhtc_ctrl: resets, output enables, request timing.
   assumes one clock domain and the bind below. */
module fhtc_monitor (
   input wire       ref_clk, reset, fdc_irq_out, fdc_irq_oe,
   input wire       dma_request_out, dma_request_oe, core_reset, core_exec,
   input wire [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   // pin reset followed by its release
   sequence s_pin_rel;
      reset ##1 !reset;
   endsequence
   rst_core_a: assert property (reset |-> core_reset) else $error("core not reset");
   rel_hold_a: assert property (s_pin_rel |-> core_reset) else $error("drive reset bit clear");
   rst_irq_a: assert property (reset |=> !fdc_irq_out) else $error("irq after reset");
   rst_req_a: assert property (reset |=> !dma_request_out) else $error("request after reset");
   rst_rdata_a: assert property (reset |=> rdata == 8'h00) else $error("read data kept");
   rst_oe_a: assert property (reset |=> !fdc_irq_oe && !dma_request_oe) else $error("outputs driven");
   core_idle_a: assert property (disable iff (reset) core_reset |=> !core_exec) else $error("exec in reset");
   req_exec_a: assert property (disable iff (reset) $rose(dma_request_out) |-> core_exec)
      else $error("request outside execution");
endmodule
bind fhtc_ctrl fhtc_monitor u_fhtc_monitor (.ref_clk(ref_clk), .reset(reset), .fdc_irq_out(fdc_irq_out),
   .fdc_irq_oe(fdc_irq_oe), .dma_request_out(dma_request_out), .dma_request_oe(dma_request_oe),
   .core_reset(core_reset), .core_exec(core_exec), .rdata(rdata));

// *** test/fhtc_dma_model.sv ***
/* system dma controller: answers a request with one acknowledged read.
   assumes the host side is silent while enable is high. */
module fhtc_dma_model (
   input  wire        ref_clk, enable, dma_request_out,
   input  wire [7:0]  rdata,
   output logic       dma_ack_n, dma_rd,
   output logic [7:0] last_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic taken = 1'b0;  // read data stand in this cycle
   initial {dma_ack_n, dma_rd, last_byte} = {1'b1, 1'b0, 8'h00};
   // one ack cycle, then take the byte; no new ack while taking
   always @(posedge ref_clk) begin
      taken <= !dma_ack_n;
      if (taken) last_byte <= rdata;
      if (enable && dma_request_out && dma_ack_n && !taken) {dma_ack_n, dma_rd} <= 2'b01;
      else {dma_ack_n, dma_rd} <= 2'b10;
   end
endmodule

// *** test/testbench.sv ***
/* bench for fhtc_ctrl: reset values, invalid opcode, dma byte read.
   assumes the disk engine side is driven here by hand. */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, reset = 1, wr = 0, hrd = 0, dma_on = 0, rd_valid = 0, last = 0, done = 0;
   logic [2:0] addr = 0;
   logic [7:0] wdata = 0, got, last_byte;
   wire [7:0] rdata;
   wire irq, irq_oe, req, req_oe, ack_n, dma_rd, exec;
   int errors = 0, n_compared = 0, cycles = 0;
   fhtc_ctrl u_fhtc_ctrl (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(hrd | dma_rd), .rdata(rdata), .dma_ack_n(ack_n), .terminal_count(1'b0), .fdc_irq_out(irq),
      .fdc_irq_oe(irq_oe), .dma_request_out(req), .dma_request_oe(req_oe), .density_select(),
      .core_reset(), .core_exec(exec), .core_write(), .core_tc(), .core_rd_valid(rd_valid),
      .core_rd_data(8'ha5), .core_sector_last(last), .core_rd_ready(), .core_wr_take(1'b0),
      .core_wr_avail(), .core_wr_data(), .core_done(done), .core_overrun(1'b0));
   fhtc_dma_model u_fhtc_dma_model (.ref_clk(ref_clk), .enable(dma_on), .dma_request_out(req & req_oe),
      .rdata(rdata), .dma_ack_n(ack_n), .dma_rd(dma_rd), .last_byte(last_byte));
   initial forever #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (++cycles == 20000) begin errors++; end_of_test(); end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin errors++; $display("ERROR %0t: got %h want %h", $time, seen, exp); end
   endtask
   // one bus cycle; read data taken in the cycle after
   task automatic bus(input bit w, input logic [2:0] a, input logic [7:0] d);
      addr <= a; wdata <= d; wr <= w; hrd <= !w;
      @(posedge ref_clk);
      wr <= 1'b0; hrd <= 1'b0;
      #1 got = rdata;
   endtask
   // command byte after polling for ready and host direction
   task automatic put(input logic [7:0] b);
      int k;
      k = 0;
      bus(0, 3'h4, 8'h00);
      while (got[7:6] !== 2'b10 && k < 20) begin bus(0, 3'h4, 8'h00); k++; end
      bus(1, 3'h5, b);
      bus(0, 3'h4, 8'h00); chk({got[7], 7'h00}, 8'h00);
   endtask
   task automatic wait_on(input int which);
      for (int k = 0; k < 40 && (which ? exec : irq) !== 1'b1; k++) begin @(posedge ref_clk); #1; end
   endtask
   task automatic t_reset;
      bus(0, 3'h0, 8'h00); chk(got, 8'h02);
      bus(0, 3'h2, 8'h00); chk(got, 8'h04);
      bus(0, 3'h1, 8'h00); chk(got, 8'h00);
      bus(1, 3'h2, 8'h08); bus(0, 3'h4, 8'h00); bus(0, 3'h4, 8'h00); chk(got, 8'h80);
      chk({7'h00, irq_oe & req_oe}, 8'h01);
   endtask
   task automatic t_invalid;
      put(8'h1f); wait_on(0); chk({7'h00, irq}, 8'h01);
      put(8'h08); wait_on(0); chk({7'h00, irq}, 8'h01);
      bus(0, 3'h4, 8'h00); chk(got, 8'hd0);
      bus(0, 3'h5, 8'h00); chk(got, 8'h80);
      bus(0, 3'h5, 8'h00); chk(got, 8'h00);
      bus(0, 3'h4, 8'h00); chk(got, 8'h80);
   endtask
   task automatic t_dma_read;
      put(8'h03); put(8'h00); put(8'h00);
      put(8'h06); repeat (8) put(8'h00);
      dma_on <= 1'b1; wait_on(1); chk({7'h00, exec}, 8'h01);
      rd_valid <= 1'b1; last <= 1'b1; @(posedge ref_clk); rd_valid <= 1'b0; last <= 1'b0;
      for (int k = 0; k < 20 && last_byte !== 8'ha5; k++) @(posedge ref_clk);
      #1 chk(last_byte, 8'ha5);
      chk({7'h00, req}, 8'h00);
      done <= 1'b1; @(posedge ref_clk); done <= 1'b0; dma_on <= 1'b0;
      wait_on(0); chk({7'h00, irq}, 8'h01);
      bus(0, 3'h5, 8'h00); chk(got, 8'h40);
      repeat (6) bus(0, 3'h5, 8'h00);
      bus(0, 3'h4, 8'h00); chk(got, 8'h80);
   endtask
   task automatic end_of_test;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset(); t_invalid(); t_dma_read();
      end_of_test();
   end
endmodule
